// >>> verilog/sadc_pkg.sv
// Constants for the SAR converter control block: register map, field
// positions, reset values and timing counts.
// Assumes the core clock is the oscillator clock at 200 MHz.
//
// Notes on behaviour
// [RQ1] Eight channels, 10-bit successive approximation result
// [RQ2] Result low byte, bits 9:8 in high
// [RQ3] Channel pin needs both function-select bits set
// [RQ4] Conversion clock runs only when enable set
// [RQ5] Prescale codes 0,1,2 divide by 1,2,4
// [RQ6] Software keeps conversion clock within 2-16 MHz
// [RQ7] One conversion takes about 4 us
// [RQ8] Start bit self-clears one cycle after write
// [RQ9] Done bit set at end, low while converting
// [RQ10] Result and done bit update together
// [RQ11] Conversions repeat continuously once started
// [RQ12] Flag set on done rising, software clears
// [RQ13] Interrupt request when flag and enable set
// [RQ14] Power bit off shuts converter, 16 ms calibration
// [RQ15] Channel field code n selects pin n
// [RQ16] Control register resets to zero
// [RQ17] Result held; writing start zero does nothing
package sadc_pkg;

	// Register addresses on the special-function bus
	localparam logic [7:0] ADDR_PRESCALER  = 8'h94;
	localparam logic [7:0] ADDR_RESULT_LO  = 8'h95;
	localparam logic [7:0] ADDR_RESULT_HI  = 8'h96;
	localparam logic [7:0] ADDR_CONTROL    = 8'h97;

	// Reset values
	localparam logic [7:0] PRESCALER_RST   = 8'h00;
	localparam logic [7:0] CONTROL_RST     = 8'h00;
	localparam logic [9:0] RESULT_RST      = 10'h000;

	// Control register field positions
	localparam int CTL_DONE_BIT   = 0;
	localparam int CTL_START_BIT  = 1;
	localparam int CTL_CHAN_LSB   = 2;
	localparam int CTL_PWR_BIT    = 5;
	localparam int CTL_IRQEN_BIT  = 6;
	localparam int CTL_IRQF_BIT   = 7;

	// Prescaler register field positions
	localparam int PS_CODE_LSB    = 0;
	localparam int PS_CLKEN_BIT   = 3;

	// Prescale codes
	localparam logic [2:0] PS_DIV1 = 3'h0;
	localparam logic [2:0] PS_DIV2 = 3'h1;
	localparam logic [2:0] PS_DIV4 = 3'h2;

	// Timing figures
	localparam int CLK_FREQ_KHZ     = 200000;
	localparam int CONV_TIME_NS     = 4000;
	localparam int CONV_CLK_TYP_MHZ = 8;
	localparam int CAL_TIME_MS      = 16;

	// Conversion length in conversion-clock ticks (rounded down)
	localparam int CONV_TICKS   = CONV_TIME_NS * CONV_CLK_TYP_MHZ / 1000;
	// Ten decision ticks, the rest is sampling
	localparam int RES_BITS     = 10;
	localparam int SAMPLE_TICKS = CONV_TICKS - RES_BITS;
	// Calibration wait in core clock cycles
	localparam int CAL_CYCLES   = CAL_TIME_MS * CLK_FREQ_KHZ;

	// Converter sequencer states
	typedef enum logic [1:0]
	{
		SADC_IDLE,
		SADC_SAMPLE,
		SADC_CONVERT
	} sadc_state_e;

endpackage

// >>> verilog/sadc_clk_div.sv
// Conversion clock divider: one-cycle tick pulses at the oscillator
// rate divided by 1, 2 or 4.
// Assumes the core clock is the oscillator clock.
`timescale 1ns/10ps

module sadc_clk_div
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Control
	input  wire logic       clkEn,
	input  wire logic [2:0] psCode,
	// Tick out
	output logic            tickOut
);
	import sadc_pkg::*;

	logic [1:0] divCnt_ff;  // Divide counter, held at zero while disabled
	logic       tickSel;    // Tick for the chosen ratio

	// Divide counter runs only while enabled, so a stopped clock restarts clean
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			divCnt_ff <= 2'h0;
		else if (!clkEn)
			divCnt_ff <= 2'h0;
		else
			divCnt_ff <= divCnt_ff + 2'h1;
	end

	// Ratio decode; unlisted codes fall back to the slowest rate
	always_comb
	begin
		case (psCode)
			PS_DIV1: tickSel = 1'b1;                 // RQ5
			PS_DIV2: tickSel = divCnt_ff[0];         // RQ5
			PS_DIV4: tickSel = &divCnt_ff;           // RQ5
			default: tickSel = &divCnt_ff;
		endcase
	end

	assign tickOut = clkEn & tickSel;  // RQ4

endmodule

// >>> verilog/sadc_ctrl.sv
// Top of the SAR converter control block: special-function registers,
// conversion clock, calibration wait, sequencer and result capture.
// Assumes an analog core that follows the DAC code and reports the
// comparator result one conversion tick later.
`timescale 1ns/10ps

module sadc_ctrl
#(
	parameter int CHANNELS   = 8,
	parameter int CAL_CYCLES = sadc_pkg::CAL_CYCLES
)
(
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst,
	// Special-function register port
	input  wire logic [7:0]          sfrAddr,
	input  wire logic                sfrWrEn,
	input  wire logic [7:0]          sfrWrData,
	input  wire logic                sfrRdEn,
	output logic [7:0]               sfrRdData,
	// Port 1 function selects from the port block
	input  wire logic [CHANNELS-1:0] port1FuncSelA,
	input  wire logic [CHANNELS-1:0] port1FuncSelB,
	output logic [CHANNELS-1:0]      adcPinEn,
	// Analog core
	input  wire logic                compAbove,
	output logic [2:0]               muxSel,
	output logic                     muxEn,
	output logic                     sampleHold,
	output logic [9:0]               dacCode,
	output logic                     analogPwrEn,
	output logic                     convClkTick,
	// CPU interrupt request
	output logic                     irqReq
);
	import sadc_pkg::*;

	localparam int CALW = $clog2(CAL_CYCLES + 1);
	localparam int TKW  = $clog2(CONV_TICKS + 1);

	// Prescaler register fields
	logic [2:0]  psCode_ff;      // Divide code
	logic        clkEn_ff;       // Conversion clock enable
	// Control register fields
	logic        irqFlag_ff;     // Completion flag
	logic        irqEn_ff;       // Interrupt enable
	logic        pwrEn_ff;       // Converter power
	logic [2:0]  chanSel_ff;     // Channel select
	logic        startBit_ff;    // Start bit as read back
	logic        doneBit_ff;     // Conversion done
	// Sequencer
	sadc_state_e state_ff;       // Current state
	sadc_state_e nxt_state;      // Next state
	logic [TKW-1:0] tickCnt_ff;  // Ticks within a phase
	logic [3:0]  bitIdx_ff;      // Bit under decision
	logic [9:0]  sarReg_ff;      // Trial code
	logic [9:0]  result_ff;      // Last finished result
	logic        runFlag_ff;     // Continuous mode armed
	logic [CALW-1:0] calCnt_ff;  // Calibration countdown
	logic        calDone;        // Calibration finished
	logic        convTick;       // Conversion clock enable pulse
	logic        finish;         // Last decision this cycle
	logic        begin_conv;     // New conversion starts
	// Bus decode and done edge
	logic        wrCtl;          // Control register write
	logic        wrPs;           // Prescaler register write
	logic        doneRise;       // Done bit rising this cycle

	assign wrCtl = sfrWrEn && (sfrAddr == ADDR_CONTROL);
	assign wrPs  = sfrWrEn && (sfrAddr == ADDR_PRESCALER);

	// Conversion clock divider
	sadc_clk_div u_div
	(
		.core_clk (core_clk),
		.rst      (rst),
		.clkEn    (clkEn_ff),
		.psCode   (psCode_ff),
		.tickOut  (convTick)
	);

	assign convClkTick = convTick;

	// Pin routing: a channel pin needs both select bits
	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_pin
			assign adcPinEn[gi] = port1FuncSelA[gi] & port1FuncSelB[gi];  // RQ3
		end
	endgenerate

	// Prescaler register
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			psCode_ff <= PRESCALER_RST[PS_CODE_LSB +: 3];
			clkEn_ff  <= PRESCALER_RST[PS_CLKEN_BIT];  // RQ4
		end
		else if (wrPs)
		begin
			psCode_ff <= sfrWrData[PS_CODE_LSB +: 3];
			clkEn_ff  <= sfrWrData[PS_CLKEN_BIT];
		end
	end

	// Plain control fields
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			irqEn_ff   <= CONTROL_RST[CTL_IRQEN_BIT];     // RQ16
			pwrEn_ff   <= CONTROL_RST[CTL_PWR_BIT];       // RQ16
			chanSel_ff <= CONTROL_RST[CTL_CHAN_LSB +: 3]; // RQ16
		end
		else if (wrCtl)
		begin
			irqEn_ff   <= sfrWrData[CTL_IRQEN_BIT];
			pwrEn_ff   <= sfrWrData[CTL_PWR_BIT];
			chanSel_ff <= sfrWrData[CTL_CHAN_LSB +: 3];
		end
	end

	// Start bit reads 1 for exactly one cycle after a write of 1
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			startBit_ff <= 1'b0;
		else
			startBit_ff <= wrCtl && sfrWrData[CTL_START_BIT];  // RQ8 RQ17
	end

	// Continuous mode: armed by start, dropped by power-off
	// A start written while unpowered is dropped, since the core is dark
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			runFlag_ff <= 1'b0;
		else if (!pwrEn_ff)
			runFlag_ff <= 1'b0;                         // RQ14
		else if (wrCtl && sfrWrData[CTL_START_BIT])
			runFlag_ff <= 1'b1;                         // RQ8 RQ11
	end

	// Calibration wait after power-on; start may be written early and
	// the first conversion simply holds off until the wait ends
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			calCnt_ff <= CALW'(CAL_CYCLES);
		else if (!pwrEn_ff)
			calCnt_ff <= CALW'(CAL_CYCLES);             // RQ14
		else if (calCnt_ff != '0)
			calCnt_ff <= calCnt_ff - CALW'(1);
	end

	assign calDone = pwrEn_ff && (calCnt_ff == '0);

	// Sequencer transitions
	assign finish     = (state_ff == SADC_CONVERT) && convTick && (bitIdx_ff == 4'h0);
	assign begin_conv = (state_ff == SADC_IDLE) && runFlag_ff && calDone && convTick;

	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			SADC_IDLE:
			begin
				if (begin_conv)
					nxt_state = SADC_SAMPLE;
			end
			SADC_SAMPLE:
			begin
				// Hold input for the sampling part of the conversion
				if (convTick && (tickCnt_ff == TKW'(SAMPLE_TICKS - 1)))
					nxt_state = SADC_CONVERT;           // RQ7
			end
			SADC_CONVERT:
			begin
				// Back to back while armed, no idle tick between
				if (finish)
					nxt_state = runFlag_ff ? SADC_SAMPLE : SADC_IDLE;  // RQ11
			end
			default:
				nxt_state = SADC_IDLE;
		endcase
	end

	// State register; power-off aborts any conversion at once
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_ff <= SADC_IDLE;
		else if (!pwrEn_ff)
			state_ff <= SADC_IDLE;                      // RQ14
		else
			state_ff <= nxt_state;
	end

	// Sample tick counter
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			tickCnt_ff <= '0;
		else if (state_ff != SADC_SAMPLE)
			tickCnt_ff <= '0;
		else if (convTick)
			tickCnt_ff <= tickCnt_ff + TKW'(1);
	end

	// Successive approximation: each tick decides one bit from the
	// comparator and raises the trial for the next lower bit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sarReg_ff <= 10'h000;
			bitIdx_ff <= 4'h0;
		end
		else if ((state_ff == SADC_SAMPLE) && (nxt_state == SADC_CONVERT))
		begin
			sarReg_ff <= 10'h200;                       // RQ1
			bitIdx_ff <= 4'(RES_BITS - 1);
		end
		else if ((state_ff == SADC_CONVERT) && convTick)
		begin
			sarReg_ff[bitIdx_ff] <= compAbove;          // RQ1
			if (bitIdx_ff != 4'h0)
			begin
				sarReg_ff[bitIdx_ff - 4'h1] <= 1'b1;
				bitIdx_ff <= bitIdx_ff - 4'h1;
			end
		end
	end

	// Result capture at the final decision, same edge as done bit
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			result_ff <= RESULT_RST;
		else if (finish)
		begin
			result_ff           <= sarReg_ff;           // RQ10 RQ17
			result_ff[0]        <= compAbove;
		end
	end

	// Done bit: set wins over a software clear in the same cycle,
	// cleared by hardware whenever a conversion begins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			doneBit_ff <= CONTROL_RST[CTL_DONE_BIT];
		else if (finish)
			doneBit_ff <= 1'b1;                         // RQ9 RQ10
		else if ((state_ff == SADC_SAMPLE) || begin_conv)
			doneBit_ff <= 1'b0;                         // RQ9
		else if (wrCtl && !sfrWrData[CTL_DONE_BIT])
			doneBit_ff <= 1'b0;                         // RQ9
	end

	assign doneRise = finish && !doneBit_ff;

	// Interrupt flag: set on done rising, software clears by writing 0
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			irqFlag_ff <= CONTROL_RST[CTL_IRQF_BIT];
		else if (doneRise)
			irqFlag_ff <= 1'b1;                         // RQ12
		else if (wrCtl && !sfrWrData[CTL_IRQF_BIT])
			irqFlag_ff <= 1'b0;                         // RQ12
	end

	assign irqReq = irqFlag_ff & irqEn_ff;              // RQ13

	// Registered read data; unmapped addresses read zero
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			sfrRdData <= 8'h00;
		else if (sfrRdEn)
		begin
			case (sfrAddr)
				ADDR_PRESCALER: sfrRdData <= {4'h0, clkEn_ff, psCode_ff};
				ADDR_RESULT_LO: sfrRdData <= result_ff[7:0];          // RQ2
				ADDR_RESULT_HI: sfrRdData <= {6'h00, result_ff[9:8]}; // RQ2
				ADDR_CONTROL:   sfrRdData <= {irqFlag_ff, irqEn_ff, pwrEn_ff,
				                              chanSel_ff, startBit_ff, doneBit_ff};
				default:        sfrRdData <= 8'h00;
			endcase
		end
	end

	// Analog core drive
	assign analogPwrEn = pwrEn_ff;                                  // RQ14
	assign muxSel      = chanSel_ff;                                // RQ15
	assign muxEn       = pwrEn_ff & adcPinEn[chanSel_ff];           // RQ3 RQ15
	assign sampleHold  = (state_ff == SADC_SAMPLE);
	assign dacCode     = sarReg_ff;

endmodule

// >>> verification/sadc_ctrl_checker.sv
// Port-level checker for the converter control block.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/10ps
module sadc_ctrl_checker
#(
	parameter int CHANNELS = 8
)
(
	// Clock and reset
	input wire logic                core_clk,
	input wire logic                rst,
	// Register port
	input wire logic [7:0]          sfrAddr,
	input wire logic                sfrWrEn,
	input wire logic [7:0]          sfrWrData,
	input wire logic                sfrRdEn,
	input wire logic [7:0]          sfrRdData,
	// Pins and analog core
	input wire logic [CHANNELS-1:0] port1FuncSelA,
	input wire logic [CHANNELS-1:0] port1FuncSelB,
	input wire logic [CHANNELS-1:0] adcPinEn,
	input wire logic                compAbove,
	input wire logic [2:0]          muxSel,
	input wire logic                muxEn,
	input wire logic                sampleHold,
	input wire logic [9:0]          dacCode,
	input wire logic                analogPwrEn,
	input wire logic                convClkTick,
	input wire logic                irqReq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	pin_gate_a: assert property (adcPinEn == (port1FuncSelA & port1FuncSelB))
		else $error("pin enable differs from select bits");
	mux_gate_a: assert property (muxEn == (analogPwrEn && adcPinEn[muxSel]))
		else $error("mux enable wrong");
	pwr_stop_a: assert property (!analogPwrEn |=> !sampleHold)
		else $error("sampling while unpowered");
	// One cycle of slack, though the tick is already gated off from the cycle after the write
	clk_gate_a: assert property (sfrWrEn && sfrAddr == 8'h94 && !sfrWrData[3] |=> ##1 !convClkTick [*4])
		else $error("tick with clock disabled");
	high_zero_a: assert property (sfrRdEn && sfrAddr == 8'h96 |=> sfrRdData[7:2] == 6'h00)
		else $error("high result reserved bits set");
	pwr_read_a: assert property (sfrRdEn && sfrAddr == 8'h97 |=>
		sfrRdData[5] == $past(analogPwrEn) && sfrRdData[4:2] == $past(muxSel))
		else $error("power or channel mismatch");
	irq_level_a: assert property (sfrRdEn && sfrAddr == 8'h97 |=>
		$past(irqReq) == (sfrRdData[7] && sfrRdData[6]))
		else $error("interrupt request mismatch");
	trial_msb_a: assert property ($fell(sampleHold) && analogPwrEn |-> dacCode == 10'h200)
		else $error("first trial code wrong");
endmodule

bind sadc_ctrl sadc_ctrl_checker #(.CHANNELS(CHANNELS)) u_chk (.core_clk, .rst, .sfrAddr, .sfrWrEn,
	.sfrWrData, .sfrRdEn, .sfrRdData, .port1FuncSelA, .port1FuncSelB, .adcPinEn, .compAbove,
	.muxSel, .muxEn, .sampleHold, .dacCode, .analogPwrEn, .convClkTick, .irqReq);

// >>> verification/sadc_analog_model.sv
// Behavioural analog core: sample-and-hold of the routed pin and a
// comparator against the trial code. Assumes eight 10-bit pin levels.
`timescale 1ns/10ps
module sadc_analog_model
(
	// Clock
	input  wire logic            core_clk,
	// Control from the block
	input  wire logic            sampleHold,
	input  wire logic            muxEn,
	input  wire logic [2:0]      muxSel,
	input  wire logic [9:0]      dacCode,
	// Pin levels
	input  wire logic [7:0][9:0] levels,
	// Comparator out
	output logic                 compAbove
);
	logic [9:0] heldLvl_ff;         // Held sample
	logic       noise_ff = 1'b0;    // Meaningless level while unrouted
	// Track the routed pin while sampling; a plain always, since the
	// toggle carries a start value that a strict tool would count as a second driver
	always @(posedge core_clk)
	begin
		if (sampleHold && muxEn)
			heldLvl_ff <= levels[muxSel];
		noise_ff <= ~noise_ff;
	end
	// Toggling answer when unrouted, so a gating slip cannot pass
	assign compAbove = muxEn ? (heldLvl_ff >= dacCode) : noise_ff;
endmodule

// >>> verification/sadc_ctrl_test.sv
// Self-checking bench for the converter control block.
// Assumes the analog model as far side and a short calibration count.
`timescale 1ns/10ps
module sadc_ctrl_test;
	import sadc_pkg::*;
	localparam int CAL = 20;       // Short calibration for simulation
	localparam int PER = 32 * 4;   // Conversion period at divide by 4
	logic            core_clk = 1'b0;
	logic            rst = 1'b1;
	logic [7:0]      sfrAddr = 8'h00;
	logic            sfrWrEn = 1'b0;
	logic [7:0]      sfrWrData = 8'h00;
	logic            sfrRdEn = 1'b0;
	logic [7:0]      sfrRdData;
	logic [7:0]      port1FuncSelA = 8'hFF;
	logic [7:0]      port1FuncSelB = 8'hFF;
	logic [7:0]      adcPinEn;
	logic            compAbove;
	logic [2:0]      muxSel;
	logic            muxEn;
	logic            sampleHold;
	logic [9:0]      dacCode;
	logic            analogPwrEn;
	logic            convClkTick;
	logic            irqReq;
	logic [7:0][9:0] lvl;
	int              bad_count = 0;
	int              comparisons = 0;
	int              cyc = 0;
	sadc_ctrl #(.CAL_CYCLES(CAL)) dut (.core_clk, .rst, .sfrAddr, .sfrWrEn, .sfrWrData, .sfrRdEn,
		.sfrRdData, .port1FuncSelA, .port1FuncSelB, .adcPinEn, .compAbove, .muxSel, .muxEn,
		.sampleHold, .dacCode, .analogPwrEn, .convClkTick, .irqReq);
	sadc_analog_model core (.core_clk, .sampleHold, .muxEn, .muxSel, .dacCode, .levels(lvl), .compAbove);
	always #2.5 core_clk = ~core_clk;
	// Hang guard, well above the roughly 1200 cycles needed
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count = bad_count + 1;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrWrData <= v;
		sfrWrEn <= 1'b1;
		@(posedge core_clk);
		sfrWrEn <= 1'b0;
	endtask
	// Data is registered at the strobe edge, so look just after it
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge core_clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge core_clk);
		sfrRdEn <= 1'b0;
		#1 v = sfrRdData;
	endtask
	// Poll the flag, not done: done may stand one cycle only
	task automatic wait_flag(output int s);
		logic [7:0] v;
		s = -1;
		for (int i = 0; i < 200 && s < 0; i++)
		begin
			rd(ADDR_CONTROL, v);
			if (v[CTL_IRQF_BIT] === 1'b1)
				s = cyc;
		end
		if (s < 0)
			chk(16'h0000, 16'hFFFF);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		automatic logic [7:0] regs[5] = '{8'h94, 8'h95, 8'h96, 8'h97, 8'h90};
		automatic logic [7:0] psv[4] = '{8'h02, 8'h08, 8'h09, 8'h0A};
		automatic int tks[4] = '{0, 16, 8, 4};
		automatic logic [2:0] chs[3] = '{3'h0, 3'h5, 3'h7};
		logic [7:0] d;
		logic       ie;
		int         n;
		int         s0;
		int         s1;
		for (int i = 0; i < 8; i++)
			lvl[i] = 10'(i * 131 + 7);
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		// Reset values; result write and unmapped read refused
		wr(ADDR_RESULT_LO, 8'hFF);
		foreach (regs[i])
		begin
			rd(regs[i], d);
			chk(d, 8'h00);
		end
		$display("test reset values done");
		// Tick rate per prescale code, gated by the enable bit
		for (int c = 0; c < 4; c++)
		begin
			wr(ADDR_PRESCALER, psv[c]);
			repeat (4) @(posedge core_clk);
			n = 0;
			repeat (16)
			begin
				@(posedge core_clk);
				#1 n += convClkTick;
			end
			chk(16'(n), 16'(tks[c]));
		end
		$display("test prescaler done");
		// Divide by 4 stays enabled; software owns the rate choice
		wr(ADDR_PRESCALER, 8'h0A);
		wr(ADDR_CONTROL, 8'h20);
		repeat (CAL + 4) @(posedge core_clk);
		foreach (chs[k])
		begin
			ie = (chs[k] != 3'h7);
			wr(ADDR_CONTROL, {1'b0, ie, 1'b1, chs[k], 2'b10});
			rd(ADDR_CONTROL, d);
			chk(d[CTL_START_BIT], 1'b0);
			wait_flag(s0);
			wr(ADDR_CONTROL, {1'b0, ie, 1'b1, chs[k], 2'b00});
			wait_flag(s1);
			chk(16'(s1 - s0 >= PER - 2 && s1 - s0 <= PER + 2), 16'h0001);
			rd(ADDR_RESULT_LO, d);
			chk(d, lvl[chs[k]][7:0]);
			rd(ADDR_RESULT_HI, d);
			chk(d, {6'h00, lvl[chs[k]][9:8]});
			rd(ADDR_CONTROL, d);
			chk({irqReq, d[CTL_IRQF_BIT]}, {ie, 1'b1});
		end
		$display("test conversions done");
		// Power off aborts; start is then ignored and the result kept
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_CONTROL, 8'h02);
		@(posedge core_clk);
		port1FuncSelB <= 8'h7F;
		repeat (PER * 2) @(posedge core_clk);
		rd(ADDR_CONTROL, d);
		chk(d, 8'h00);
		rd(ADDR_RESULT_LO, d);
		chk(d, lvl[7][7:0]);
		$display("test power off done");
		end_of_test();
	end
endmodule
